// *** core/record_retransmit_engine.sv ***
// record retransmit engine: parses the host record stream and feeds port MACs
`timescale 1ns/1ps
module record_retransmit_engine #(
  parameter int PORTS = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // record stream from transmit memory, 64-bit words
  input wire logic rec_valid,
  input wire logic [63:0] rec_data,
  output logic rec_ready,
  // beats toward the port MACs
  output record_replay_pkg::tx_beat_type tx_beat,
  output logic tx_valid,
  input wire logic [PORTS-1:0] tx_ready,
  // link state pins and MAC buffer levels from outside the clock domain
  input wire logic [PORTS-1:0] link_up,
  input wire logic [PORTS-1:0] mac_buf_empty,
  // memory split to the memory controller, interrupt
  output logic [31:0] tx_mem_mb,
  output logic irq
);
  import record_replay_pkg::*;

  typedef enum logic [1:0] {
    ST_HEADER = 2'b00,
    ST_SKIP = 2'b01,
    ST_SEND = 2'b10,
    ST_DROP = 2'b11
  } parse_state_type;

  // software registers
  logic [31:0] control;
  logic [31:0] status;
  logic [31:0] mask;
  logic [7:0] link_type;
  logic [31:0] sent_count;
  // synchronised pins: first stage read only by second
  logic [PORTS-1:0] link_meta, link_sync;
  logic [PORTS-1:0] empty_meta, empty_sync;
  // parser state
  parse_state_type state;
  logic [15:0] remain;     // bytes of record still to consume
  logic [15:0] frame_left; // frame bytes still to send
  logic [2:0] cur_port;
  logic [PORTS-1:0] in_frame;
  logic beat_take, hdr_take, hdr_ok, hdr_aligned, hdr_type_ok, hdr_drop;
  logic port_live;
  logic [15:0] hdr_len;
  logic [2:0] hdr_port;
  logic [PORTS-1:0] next_underrun;
  logic align_ev, type_ev, block_ev;
  logic bus_write;
  logic [31:0] status_clr; // status bits written with a one this cycle
  logic [31:0] status_set; // status events raised this cycle
  logic first_beat;        // next body word is the first of its record

  // whole words needed for a byte count
  function automatic logic [15:0] words_of(input logic [15:0] bytes);
    words_of = (bytes + WORD_BYTES - 16'h0001) / WORD_BYTES;
  endfunction

  // two flip-flop synchronisers for pin inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_meta <= '0;
      link_sync <= '0;
      empty_meta <= '0;
      empty_sync <= '0;
    end else begin
      link_meta <= link_up;
      link_sync <= link_meta;
      empty_meta <= mac_buf_empty;
      empty_sync <= empty_meta;
    end
  end

  // header decode
  assign hdr_len = rec_data[HDR_LEN_LSB +: HDR_LEN_W];
  assign hdr_port = rec_data[HDR_PORT_LSB +: 3];
  // badly aligned lengths cannot be framed; their header word alone is dropped and flagged
  assign hdr_aligned = (hdr_len[2:0] == 3'b000) && (hdr_len > HDR_BYTES); // RULE7
  assign hdr_type_ok = rec_data[HDR_TYPE_LSB +: HDR_TYPE_W] == link_type; // RULE6
  assign hdr_ok = hdr_aligned && hdr_type_ok && (32'(hdr_port) < PORTS);
  assign hdr_drop = control[CTRL_SUPPRESS] && rec_data[HDR_RXERR_BIT]; // RULE13
  // a record for a dead port waits here and blocks the stream behind it
  assign port_live = link_sync[hdr_port[$clog2(PORTS)-1:0]]; // RULE8

  // the stream is consumed only when the current step can complete;
  // receive capture uses its own path and never waits on this
  always_comb begin
    unique case (state)
      ST_HEADER: rec_ready = control[CTRL_ENABLE] && (!hdr_ok || hdr_drop || port_live);
      ST_SEND: rec_ready = tx_ready[cur_port[$clog2(PORTS)-1:0]]; // RULE14 RULE1
      ST_SKIP, ST_DROP: rec_ready = 1'b1;
    endcase
  end
  assign beat_take = rec_valid && rec_ready;
  assign hdr_take = beat_take && (state == ST_HEADER);
  assign align_ev = hdr_take && !hdr_aligned;
  assign type_ev = hdr_take && hdr_aligned && !hdr_type_ok;
  assign block_ev = (state == ST_HEADER) && rec_valid && control[CTRL_ENABLE]
    && hdr_ok && !hdr_drop && !port_live;

  // record parser: one record at a time, in stream order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HEADER;
      remain <= '0;
      frame_left <= '0;
      cur_port <= '0;
      first_beat <= 1'b0;
    end else if (beat_take) begin
      unique case (state)
        ST_HEADER: begin
          remain <= hdr_len - HDR_BYTES;
          cur_port <= hdr_port; // RULE14
          first_beat <= 1'b1; // the word after a header opens the frame
          // stripping trims four bytes off what the MAC is told to send
          frame_left <= control[CTRL_STRIP] ? hdr_len - HDR_BYTES - CRC_BYTES
                                           : hdr_len - HDR_BYTES; // RULE9 RULE17
          if (!hdr_aligned) begin
            state <= ST_HEADER; // length cannot be trusted, resync on next word
          end else if (!hdr_ok) begin
            state <= ST_SKIP;
          end else if (hdr_drop) begin
            state <= ST_DROP; // RULE13
          end else begin
            state <= ST_SEND;
          end
        end
        ST_SEND, ST_SKIP, ST_DROP: begin
          remain <= remain - WORD_BYTES;
          first_beat <= 1'b0;
          frame_left <= (frame_left > WORD_BYTES) ? frame_left - WORD_BYTES : '0;
          // next header follows immediately, no inter-frame pacing
          if (remain <= WORD_BYTES) begin
            state <= ST_HEADER; // RULE5
          end
        end
      endcase
    end
  end

  // outgoing beat; only words from the host stream ever leave
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_beat <= '0;
      tx_valid <= 1'b0;
    end else begin
      tx_valid <= beat_take && (state == ST_SEND) && (frame_left != '0); // RULE4 RULE5
      tx_beat.data <= rec_data;
      tx_beat.port <= cur_port;
      // only the first body word of a record opens a frame; length
      // comparisons cannot tell it apart, both counters fall together
      tx_beat.sof <= first_beat; // RULE14
      tx_beat.eof <= frame_left <= WORD_BYTES; // RULE9 RULE12
      tx_beat.last_bytes <= (frame_left >= WORD_BYTES) ? 4'h8 : 4'(frame_left);
      tx_beat.add_crc <= control[CTRL_APPEND]; // RULE10 RULE11
    end
  end

  // per-port frame tracking for under-run detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (tx_valid && 32'(tx_beat.port) == p) begin
          in_frame[p] <= !tx_beat.eof;
        end
      end
    end
  end
  assign next_underrun = in_frame & empty_sync; // RULE16

  // a write lands at the edge where the master samples ack, never earlier
  assign bus_write = cyc_i && stb_i && we_i && ack_o;
  // status bits to clear and to set in this cycle
  always_comb begin
    status_clr = 32'h0000_0000;
    if (bus_write && adr_i == REG_STATUS) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          status_clr[8*b +: 8] = dat_i[8*b +: 8];
        end
      end
    end
    status_set = 32'(next_underrun);
    status_set[ST_ALIGN_ERR] = align_ev;
    status_set[ST_TYPE_ERR] = type_ev;
    status_set[ST_BLOCKED] = block_ev;
  end
  // status: events set, writing one clears; a set that meets its clear
  // in one cycle wins, so an event is never lost to a late clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~status_clr) | status_set; // RULE16
    end
  end
  assign irq = |(status & mask);

  // software writable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CONTROL_RESET;
      mask <= '0;
      tx_mem_mb <= TX_MEM_DEFAULT_MB; // RULE2
      link_type <= '0;
    end else if (bus_write) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          unique case (adr_i)
            REG_CONTROL: control[8*b +: 8] <= dat_i[8*b +: 8];
            REG_MASK: mask[8*b +: 8] <= dat_i[8*b +: 8];
            // split changes ignored while running
            REG_TX_MEM: if (!control[CTRL_ENABLE]) tx_mem_mb[8*b +: 8] <= dat_i[8*b +: 8]; // RULE3
            REG_LINK: if (b == 0) link_type <= dat_i[7:0];
            default: ;
          endcase
        end
      end
    end
  end

  // count of frames handed to MACs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_count <= '0;
    end else if (tx_valid && tx_beat.eof) begin
      sent_count <= sent_count + 32'h0000_0001;
    end
  end

  // bus answer: one wait cycle, ack for one cycle, unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      unique case (adr_i)
        REG_CONTROL: dat_o <= control;
        REG_STATUS: dat_o <= status;
        REG_MASK: dat_o <= mask;
        REG_TX_MEM: dat_o <= tx_mem_mb;
        REG_LINK: dat_o <= 32'({link_sync, 8'h00, link_type}) & 32'h00FF_FFFF;
        REG_COUNT: dat_o <= sent_count;
        default: dat_o <= '0;
      endcase
    end
  end

  // assertions
  property p_no_drop_sent;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_DROP) |-> ##1 !tx_valid;
  endproperty
  a_no_drop_sent: assert property (p_no_drop_sent) else $error("dropped record sent"); // RULE13

  property p_blocked_stall;
    @(posedge ref_clk) disable iff (!rst_n)
      block_ev |-> !rec_ready;
  endproperty
  a_blocked_stall: assert property (p_blocked_stall) else $error("dead port not blocking"); // RULE8

  property p_one_port;
    @(posedge ref_clk) disable iff (!rst_n)
      (tx_valid && !tx_beat.eof) |=> (tx_valid |-> $stable(tx_beat.port));
  endproperty
  a_one_port: assert property (p_one_port) else $error("port switched mid frame"); // RULE14

  property p_underrun_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
      (status[PORTS-1] && !bus_write) |=> status[PORTS-1];
  endproperty
  a_underrun_sticky: assert property (p_underrun_sticky) else $error("flag lost"); // RULE16

  property p_split_locked;
    @(posedge ref_clk) disable iff (!rst_n)
      control[CTRL_ENABLE] |=> $stable(tx_mem_mb);
  endproperty
  a_split_locked: assert property (p_split_locked) else $error("split moved"); // RULE3

  property p_crc_flag;
    @(posedge ref_clk) disable iff (!rst_n)
      tx_valid |-> tx_beat.add_crc == $past(control[CTRL_APPEND]);
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag wrong"); // RULE10

  property p_only_stream;
    @(posedge ref_clk) disable iff (!rst_n)
      tx_valid |-> $past(beat_take);
  endproperty
  a_only_stream: assert property (p_only_stream) else $error("beat without input"); // RULE4

  property p_strip_len;
    @(posedge ref_clk) disable iff (!rst_n)
      (hdr_take && hdr_ok && control[CTRL_STRIP])
        |=> frame_left == remain - CRC_BYTES;
  endproperty
  a_strip_len: assert property (p_strip_len) else $error("strip length wrong"); // RULE17

  property p_full_len;
    @(posedge ref_clk) disable iff (!rst_n)
      (hdr_take && hdr_ok && !control[CTRL_STRIP]) |=> frame_left == remain;
  endproperty
  a_full_len: assert property (p_full_len) else $error("unstripped length cut"); // RULE12

  property p_sof_first;
    @(posedge ref_clk) disable iff (!rst_n)
      (tx_valid && !tx_beat.eof) |=> (tx_valid |-> !tx_beat.sof);
  endproperty
  a_sof_first: assert property (p_sof_first) else $error("frame start mid frame"); // RULE14

  property p_to_header;
    @(posedge ref_clk) disable iff (!rst_n)
      (beat_take && state != ST_HEADER && remain <= WORD_BYTES) |=> state == ST_HEADER;
  endproperty
  a_to_header: assert property (p_to_header) else $error("gap after record"); // RULE5

  property p_underrun_set;
    @(posedge ref_clk) disable iff (!rst_n)
      (in_frame[PORTS-1] && empty_sync[PORTS-1]) |=> status[PORTS-1];
  endproperty
  a_underrun_set: assert property (p_underrun_set) else $error("underrun not flagged"); // RULE16

  // the slave never stretches its answer past one cycle
  property p_ack_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
endmodule

// *** core/record_replay_pkg.sv ***
// constants, field layouts and types shared by the record retransmit engine
// Summary of operation
// RULE1: receive capture never stalled by transmit activity
// RULE2: default split gives transmit sixteen megabytes
// RULE3: host keeps memory split fixed while running
// RULE4: only host supplied records are ever sent
// RULE5: records sent back to back, no pacing
// RULE6: host supplies records matching link type
// RULE7: host supplies records padded to 64 bits
// RULE8: inactive destination port blocks further delivery
// RULE9: strip option removes trailing 32-bit CRC
// RULE10: append option makes MAC add CRC
// RULE11: strip plus append gives fresh CRC
// RULE12: neither option sends stored CRC unchanged
// RULE13: suppression option drops receive errored records
// RULE14: one interface at a time, stream order
// RULE15: host commits large bursts to avoid under-run
// RULE16: sticky per-port under-run flag mid frame
// RULE17: stripping shortens transmit length by four
package record_replay_pkg;
  // bus register offsets (byte addresses)
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_TX_MEM = 8'h0C;
  localparam logic [7:0] REG_LINK = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  // control register field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_STRIP = 1;
  localparam int CTRL_APPEND = 2;
  localparam int CTRL_SUPPRESS = 3;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // default transmit memory share, in megabytes
  localparam logic [31:0] TX_MEM_DEFAULT_MB = 32'h0000_0010;
  // record header word layout (64-bit word 0)
  localparam int HDR_LEN_LSB = 0;    // byte length of whole record
  localparam int HDR_LEN_W = 16;
  localparam int HDR_PORT_LSB = 16;  // destination interface
  localparam int HDR_RXERR_BIT = 24; // receive error flag
  localparam int HDR_TYPE_LSB = 32;  // record type
  localparam int HDR_TYPE_W = 8;
  localparam logic [15:0] HDR_BYTES = 16'h0008;
  localparam logic [15:0] CRC_BYTES = 16'h0004;
  localparam logic [15:0] WORD_BYTES = 16'h0008;
  // status bit positions above the per-port under-run bits
  localparam int ST_ALIGN_ERR = 8;
  localparam int ST_TYPE_ERR = 9;
  localparam int ST_BLOCKED = 10;
  // one outgoing beat to a port MAC
  typedef struct packed {
    logic [63:0] data;
    logic [2:0] port;
    logic sof;
    logic eof;
    logic [3:0] last_bytes; // valid bytes in the eof beat, 1..8
    logic add_crc;
  } tx_beat_type;
endpackage

// *** verification/stream_host.sv ***
// host model: commits record words into the transmit stream
`timescale 1ns/1ps
module stream_host (
  // clock
  input wire logic ref_clk,
  // record stream
  input wire logic rec_ready,
  output logic rec_valid,
  output logic [63:0] rec_data,
  // pacing: a gap after each word when set
  input wire logic slow
);
  logic [63:0] q[$]; // committed words
  logic tick; // alternates for slow pacing
  initial begin
    rec_valid = 1'b0;
    rec_data = 64'h0;
    tick = 1'b0;
  end
  // a word stays up until taken; idle data toggles so stale words never match
  always @(posedge ref_clk) begin
    if (!(rec_valid && !rec_ready)) begin
      if (rec_valid) void'(q.pop_front());
      tick <= ~tick;
      if (q.size() > 0 && !(slow && tick)) begin
        rec_valid <= 1'b1;
        rec_data <= q[0];
      end else begin
        rec_valid <= 1'b0;
        rec_data <= ~rec_data;
      end
    end
  end
endmodule

// *** verification/tb_record_retransmit_engine.sv ***
// self-checking bench for the record retransmit engine
`timescale 1ns/1ps
module tb_record_retransmit_engine;
  import record_replay_pkg::*;
  // one case: control, header fields, beats expected
  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] len;
    logic [2:0] port;
    logic rxerr;
    logic [3:0] beats;
    logic [3:0] last;
    logic addc;
  } row_type;
  row_type rows [6] = '{
    '{4'h1, 16'h0018, 3'h0, 1'b0, 4'h2, 4'h8, 1'b0},
    '{4'h7, 16'h0018, 3'h1, 1'b0, 4'h2, 4'h4, 1'b1},
    '{4'h5, 16'h0010, 3'h2, 1'b0, 4'h1, 4'h8, 1'b1},
    '{4'h3, 16'h0010, 3'h3, 1'b0, 4'h1, 4'h4, 1'b0},
    '{4'h9, 16'h0018, 3'h0, 1'b1, 4'h0, 4'h0, 1'b0},
    '{4'h1, 16'h0010, 3'h1, 1'b1, 4'h1, 4'h8, 1'b0}};
  logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o, tx_mem_mb;
  logic ack_o, rec_valid, rec_ready, tx_valid, irq;
  logic [63:0] rec_data;
  logic [3:0] tx_ready = 4'hF, link_up = 4'hF, mac_buf_empty = 4'h0;
  tx_beat_type tx_beat;
  tx_beat_type beats[$]; // beats seen toward the MACs
  int n_fail = 0, n_checks = 0, cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  record_retransmit_engine #(.PORTS(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .rec_valid(rec_valid), .rec_data(rec_data), .rec_ready(rec_ready),
    .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready), .link_up(link_up),
    .mac_buf_empty(mac_buf_empty), .tx_mem_mb(tx_mem_mb), .irq(irq));
  stream_host host (.ref_clk(ref_clk), .rec_ready(rec_ready), .rec_valid(rec_valid),
    .rec_data(rec_data), .slow(slow));

  // collect every beat handed to a MAC
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1) beats.push_back(tx_beat);
  end
  // hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  function automatic logic [63:0] body(input int k);
    return {56'hA5A5_0000_0000_00, 8'(k)};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // header then whole 64-bit body words
  task automatic rec(input logic [15:0] len, input logic [2:0] p, input logic e,
                     input logic [7:0] typ);
    host.q.push_back({24'h0, typ, 7'h0, e, 5'h0, p, len});
    for (int k = 0; k < (int'(len) - 8) / 8; k++) host.q.push_back(body(k));
  endtask
  task automatic drain;
    for (int k = 0; k < 300 && (host.q.size() != 0 || rec_valid); k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic results;
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    chk(tx_mem_mb, 32'h10);
    chk({rec_ready, irq, tx_valid}, 3'h0);
    rst_n <= 1'b1;
    wb(1'b0, REG_TX_MEM, 32'h0, rd);
    chk(rd, TX_MEM_DEFAULT_MB);
    foreach (rows[i]) begin
      wb(1'b1, REG_CONTROL, {28'h0, rows[i].ctrl}, rd);
      beats.delete();
      rec(rows[i].len, rows[i].port, rows[i].rxerr, 8'h00);
      drain();
      chk(64'(beats.size()), 64'(rows[i].beats));
      if (rows[i].beats != 0) begin
        chk({beats[0].sof, beats[$].eof}, 2'h3);
        chk(beats[$].last_bytes, rows[i].last);
        chk(beats[0].add_crc, rows[i].addc);
        chk(beats[0].port, rows[i].port);
        chk(beats[0].data, body(0));
        chk(beats[$].data, body(int'(rows[i].beats) - 1));
        if (rows[i].beats > 1) chk({beats[1].sof, beats[0].eof}, 2'h0);
      end
    end
    // three records to three ports, sent in stream order
    wb(1'b1, REG_CONTROL, 32'h1, rd);
    beats.delete();
    rec(16'h0010, 3'h1, 1'b0, 8'h00);
    rec(16'h0010, 3'h2, 1'b0, 8'h00);
    rec(16'h0018, 3'h3, 1'b0, 8'h00);
    drain();
    chk(64'(beats.size()), 64'h4);
    chk({beats[0].port, beats[1].port, beats[2].port, beats[3].port}, 12'h29B);
    // misaligned and wrong type records are skipped; only align error unmasked
    wb(1'b1, REG_MASK, 32'h100, rd);
    beats.delete();
    rec(16'h000C, 3'h0, 1'b0, 8'h00);
    rec(16'h0010, 3'h0, 1'b0, 8'h05);
    rec(16'h0010, 3'h2, 1'b0, 8'h00);
    drain();
    chk(64'(beats.size()), 64'h1);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk({rd, irq}, {32'h300, 1'b1});
    wb(1'b1, REG_STATUS, 32'h100, rd);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk({rd, irq}, {32'h200, 1'b0});
    // dead destination link holds the stream
    link_up <= 4'hB;
    repeat (4) @(posedge ref_clk); // let the dead link cross the synchroniser
    beats.delete();
    rec(16'h0010, 3'h2, 1'b0, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk({rec_ready, 64'(beats.size())}, 65'h0);
    link_up <= 4'hF;
    drain();
    chk(64'(beats.size()), 64'h1);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h600);
    wb(1'b1, REG_STATUS, 32'h600, rd);
    // slow host starves port 3 mid frame while its MAC runs dry
    slow <= 1'b1;
    rec(16'h0018, 3'h3, 1'b0, 8'h00);
    void'(host.q.pop_back());
    repeat (12) @(posedge ref_clk);
    mac_buf_empty <= 4'h8;
    repeat (4) @(posedge ref_clk);
    mac_buf_empty <= 4'h0;
    host.q.push_back(body(1));
    drain();
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h8);
    wb(1'b1, REG_STATUS, 32'h8, rd);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h0);
    // eleven frames were handed over so far; link state reads back
    wb(1'b0, REG_COUNT, 32'h0, rd);
    chk(rd, 32'hB);
    wb(1'b0, REG_LINK, 32'h0, rd);
    chk(rd, 32'h000F_0000);
    // memory split only moves while idle; unmapped reads zero
    wb(1'b1, REG_TX_MEM, 32'h20, rd);
    @(posedge ref_clk);
    chk(tx_mem_mb, 32'h10);
    wb(1'b1, REG_CONTROL, 32'h0, rd);
    wb(1'b1, REG_TX_MEM, 32'h20, rd);
    @(posedge ref_clk);
    chk(tx_mem_mb, 32'h20);
    wb(1'b0, 8'hFC, 32'h0, rd);
    chk(rd, 32'h0);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    chk({tx_mem_mb, rec_ready}, {32'h10, 1'b0});
    results();
  end
endmodule
